// *** core/ptpwm_core.sv ***
// Purpose: pulse train and pwm output on two discrete output lines
// Assumes: inputs synchronous to i_sys_clk; one strobe at a time
// Notes:   periods come from a phase accumulator, so the period is exact
//          on average with one clock of jitter

`timescale 1ns/1ps

module ptpwm_core
  import ptpwm_pkg::*;
#(
  parameter int unsigned ERR_HOLD = ERR_HOLD_CYC
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [DATA_W-1:0] o_rdata,
  output logic                   o_first_output_line,
  output logic                   o_second_output_line,
  output logic                   o_pulse_width_error_flag,
  output logic                   o_duty_setting_error_flag,
  output logic                   o_frequency_setting_error_flag
);

  // --------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------
  localparam int unsigned HOLD_W = 16;

  if (ERR_HOLD < 1 || ERR_HOLD > 65535) begin : g_bad_hold
    $error("ERR_HOLD must lie in 1 to 65535");
  end

  // the accumulator must hold a full period and the top duty threshold
  if (32'(FREQ_MAX) >= 32'(ACC_WRAP) || 32'(DUTY_MAX) * 32'(DUTY_STEP) > 32'(ACC_WRAP)) begin : g_bad_acc
    $error("accumulator too narrow for the frequency or duty range");
  end

  if (ST_DIR_BIT >= DATA_W || CTRL_EN_BIT >= DATA_W) begin : g_bad_field
    $error("status or control field lies outside the data word");
  end

  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(ERR_HOLD);

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] output_function_select;
  logic [DATA_W-1:0] frequency_setting_word;
  logic [DATA_W-1:0] on_duty_setting_word;
  logic              output_enable_flag;
  logic [ACC_W-1:0]  acc;
  logic [2:0]        err_flag;
  logic [2:0]        err_evt;

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  wire wr_func = i_wr && (i_addr == ADDR_FUNC);
  wire wr_freq = i_wr && (i_addr == ADDR_FREQ);
  wire wr_duty = i_wr && (i_addr == ADDR_DUTY);
  wire wr_ctrl = i_wr && (i_addr == ADDR_CTRL);

  // --------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------
  // unknown function codes leave both lines idle
  ptpwm_mode_t mode;

  assign mode = (output_function_select == FUNC_FWDREV)  ? PTPWM_FWDREV  :
                (output_function_select == FUNC_STEPDIR) ? PTPWM_STEPDIR :
                (output_function_select == FUNC_PWM)     ? PTPWM_PWM     :
                PTPWM_OFF;

  wire pwm_mode = (mode == PTPWM_PWM);
  wire dir_mode = (mode == PTPWM_FWDREV) || (mode == PTPWM_STEPDIR);
  wire running  = output_enable_flag && (mode != PTPWM_OFF);

  // direction is the sign of the accepted word
  wire reverse = frequency_setting_word[DATA_W-1];

  // magnitude of the accepted word
  wire [DATA_W-1:0] freq_mag = reverse ? DATA_W'(-frequency_setting_word)
                                       : frequency_setting_word;

  // --------------------------------------------------------------------
  // frequency write check
  // --------------------------------------------------------------------
  wire              wr_neg = i_wdata[DATA_W-1];
  wire [DATA_W-1:0] wr_mag = wr_neg ? DATA_W'(-i_wdata) : i_wdata;

  wire mag_ok = (wr_mag >= FREQ_MIN) && (wr_mag <= FREQ_MAX);

  // pwm takes only a positive frequency
  wire sign_ok = !(pwm_mode && wr_neg);

  // the sign is frozen while pulse output runs
  wire sign_flip = output_enable_flag && dir_mode && (wr_neg != reverse);

  wire freq_ok   = mag_ok && sign_ok && !sign_flip;
  wire freq_take = wr_freq && freq_ok;
  wire freq_bad  = wr_freq && !freq_ok;

  // --------------------------------------------------------------------
  // duty write check
  // --------------------------------------------------------------------
  wire duty_ok   = (i_wdata <= DUTY_MAX);
  wire duty_take = wr_duty && duty_ok;
  wire duty_bad  = wr_duty && !duty_ok;

  // --------------------------------------------------------------------
  // achievable duty check
  // --------------------------------------------------------------------
  // candidate values as they will stand after this cycle
  wire [DATA_W-1:0] cand_freq = freq_take ? wr_mag : freq_mag;
  wire [DATA_W-1:0] cand_duty = duty_take ? i_wdata : on_duty_setting_word;

  wire [DATA_W-1:0] cand_off = DUTY_MAX - cand_duty;

  // on and off time in clocks scaled by the frequency
  wire [31:0] on_scaled  = 32'(cand_duty) * 32'(DUTY_STEP);
  wire [31:0] off_scaled = 32'(cand_off) * 32'(DUTY_STEP);
  wire [31:0] min_scaled = 32'(cand_freq) * 32'(MIN_PULSE_CYC);

  wire duty_edge = (cand_duty == '0) || (cand_duty == DUTY_MAX);

  wire too_short = !duty_edge &&
                   ((on_scaled < min_scaled) || (off_scaled < min_scaled));

  // recheck whenever the frequency, the duty or the enable changes in pwm mode
  wire pw_check = pwm_mode && (freq_take || duty_take || wr_ctrl);

  // enable as it will stand after this cycle; a disabling write raises nothing
  wire en_after = wr_ctrl ? i_wdata[CTRL_EN_BIT] : output_enable_flag;

  wire pw_bad = pw_check && en_after && too_short;

  assign err_evt[ST_PW_BIT]   = pw_bad;
  assign err_evt[ST_DUTY_BIT] = duty_bad;
  assign err_evt[ST_FREQ_BIT] = freq_bad;

  // --------------------------------------------------------------------
  // setting registers
  // --------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      output_function_select <= RST_FUNC;
    end else if (wr_func) begin
      output_function_select <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      frequency_setting_word <= RST_FREQ;
    end else if (freq_take) begin
      frequency_setting_word <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      on_duty_setting_word <= RST_DUTY;
    end else if (duty_take) begin
      on_duty_setting_word <= i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      output_enable_flag <= 1'b0;
    end else if (wr_ctrl) begin
      output_enable_flag <= i_wdata[CTRL_EN_BIT];
    end
  end

  // --------------------------------------------------------------------
  // self-clearing error flags
  // --------------------------------------------------------------------
  // set wins: a fresh event reloads the count
  for (genvar g = 0; g < 3; g++) begin : g_err
    logic [HOLD_W-1:0] hold;
    wire  [HOLD_W-1:0] next_hold = err_evt[g]     ? HOLD_LOAD :
                                   (hold != '0)   ? hold - 1'b1 :
                                   hold;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
        hold <= '0;
      end else begin
        hold <= next_hold;
      end
    end

    assign err_flag[g] = (hold != '0);
  end

  // --------------------------------------------------------------------
  // period accumulator
  // --------------------------------------------------------------------
  // adds the frequency each clock and wraps at the clock rate
  // held at zero while idle so each enable starts a whole period
  wire [ACC_W:0] acc_sum = {1'b0, acc} + {{(ACC_W+1-DATA_W){1'b0}}, freq_mag};

  wire [ACC_W-1:0] next_acc = !running                  ? '0 :
                              (acc_sum >= {1'b0, ACC_WRAP}) ? ACC_W'(acc_sum - {1'b0, ACC_WRAP}) :
                              acc_sum[ACC_W-1:0];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      acc <= '0;
    end else begin
      acc <= next_acc;
    end
  end

  // --------------------------------------------------------------------
  // waveform shaping
  // --------------------------------------------------------------------
  // first half of each period is the high phase
  wire pulse_hi = (acc < ACC_HALF);

  // duty threshold in accumulator units
  wire [ACC_W-1:0] duty_thr = ACC_W'(32'(on_duty_setting_word) * 32'(DUTY_STEP));

  wire pwm_hi = (acc < duty_thr);

  logic next_line1;
  logic next_line2;

  always_comb begin
    next_line1 = 1'b0;
    next_line2 = 1'b0;
    if (running) begin
      unique case (mode)
        PTPWM_FWDREV: begin
          next_line1 = pulse_hi && !reverse;
          next_line2 = pulse_hi && reverse;
        end
        PTPWM_STEPDIR: begin
          next_line1 = pulse_hi;
          next_line2 = reverse;
        end
        PTPWM_PWM: begin
          next_line1 = pwm_hi;
          next_line2 = 1'b0;
        end
        PTPWM_OFF: begin
          next_line1 = 1'b0;
          next_line2 = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_first_output_line  <= 1'b0;
      o_second_output_line <= 1'b0;
    end else begin
      o_first_output_line  <= next_line1;
      o_second_output_line <= next_line2;
    end
  end

  // --------------------------------------------------------------------
  // flag outputs
  // --------------------------------------------------------------------
  // registered copies; a fresh event shows two clocks after its write
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pulse_width_error_flag       <= 1'b0;
      o_duty_setting_error_flag      <= 1'b0;
      o_frequency_setting_error_flag <= 1'b0;
    end else begin
      o_pulse_width_error_flag       <= err_flag[ST_PW_BIT];
      o_duty_setting_error_flag      <= err_flag[ST_DUTY_BIT];
      o_frequency_setting_error_flag <= err_flag[ST_FREQ_BIT];
    end
  end

  // --------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] status_word;

  // fields placed by their named positions
  always_comb begin
    ctrl_word                = '0;
    ctrl_word[CTRL_EN_BIT]   = output_enable_flag;
    status_word              = '0;
    status_word[ST_PW_BIT]   = err_flag[ST_PW_BIT];
    status_word[ST_DUTY_BIT] = err_flag[ST_DUTY_BIT];
    status_word[ST_FREQ_BIT] = err_flag[ST_FREQ_BIT];
    status_word[ST_RUN_BIT]  = running;
    status_word[ST_DIR_BIT]  = reverse;
  end

  wire [DATA_W-1:0] rd_sel = (i_addr == ADDR_FUNC)   ? output_function_select :
                             (i_addr == ADDR_FREQ)   ? frequency_setting_word :
                             (i_addr == ADDR_DUTY)   ? on_duty_setting_word :
                             (i_addr == ADDR_CTRL)   ? ctrl_word :
                             (i_addr == ADDR_STATUS) ? status_word :
                             '0;

  // data stand only in the cycle after the read strobe
  wire [DATA_W-1:0] next_rdata = i_rd ? rd_sel : '0;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule

// *** core/ptpwm_pkg.sv ***
// Purpose: constants and types of the pulse train / pwm output block
// Assumes: 10 MHz system clock
// Notes:   register addresses are word indexes on the plain register port

package ptpwm_pkg;

  // --------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned MIN_PULSE_US   = 100;
  localparam int unsigned MIN_PULSE_CYC  = (MIN_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned ERR_HOLD_US    = 10;
  localparam int unsigned ERR_HOLD_CYC   = (ERR_HOLD_US * CLK_HZ) / 1_000_000;
  localparam int unsigned ACC_W          = 24;
  localparam logic [ACC_W-1:0] ACC_WRAP  = ACC_W'(CLK_HZ);
  localparam logic [ACC_W-1:0] ACC_HALF  = ACC_W'(CLK_HZ / 2);
  localparam logic [ACC_W-1:0] DUTY_STEP = ACC_W'(CLK_HZ / 100);

  // --------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_FUNC   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FREQ   = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_DUTY   = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;

  localparam logic [DATA_W-1:0] RST_FUNC = 16'h0000;
  localparam logic [DATA_W-1:0] RST_FREQ = 16'h0032;
  localparam logic [DATA_W-1:0] RST_DUTY = 16'h0000;

  // field positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned ST_PW_BIT     = 0;
  localparam int unsigned ST_DUTY_BIT   = 1;
  localparam int unsigned ST_FREQ_BIT   = 2;
  localparam int unsigned ST_RUN_BIT    = 3;
  localparam int unsigned ST_DIR_BIT    = 4;

  // --------------------------------------------------------------------
  // function codes and value ranges
  // --------------------------------------------------------------------
  localparam logic [DATA_W-1:0] FUNC_PWM     = 16'h0001;
  localparam logic [DATA_W-1:0] FUNC_STEPDIR = 16'h0002;
  localparam logic [DATA_W-1:0] FUNC_FWDREV  = 16'h0003;
  localparam logic [DATA_W-1:0] FREQ_MIN     = 16'h0032;
  localparam logic [DATA_W-1:0] FREQ_MAX     = 16'h1388;
  localparam logic [DATA_W-1:0] DUTY_MAX     = 16'h0064;

  typedef enum logic [1:0] {
    PTPWM_OFF     = 2'b00,
    PTPWM_FWDREV  = 2'b01,
    PTPWM_STEPDIR = 2'b10,
    PTPWM_PWM     = 2'b11
  } ptpwm_mode_t;

endpackage

// *** tb/ptpwm_chk.sv ***
// Purpose: port checker for ptpwm_core
// Assumes: no negative frequency word is written in pwm mode
// Notes:   helper registers mirror mode, enable and stored sign
`timescale 1ns/1ps
module ptpwm_chk
  import ptpwm_pkg::*;
#(
  parameter int unsigned ERR_HOLD = ERR_HOLD_CYC
) (
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              o_first_output_line,
  input wire logic              o_second_output_line,
  input wire logic              o_pulse_width_error_flag,
  input wire logic              o_duty_setting_error_flag,
  input wire logic              o_frequency_setting_error_flag
);
  // ------------------------------------------------------------------
  // helper state
  // ------------------------------------------------------------------
  localparam int HOLD_LIM = ERR_HOLD + 2;
  logic [DATA_W-1:0] mode_q;
  logic              en_q;
  logic              sign_q;
  logic [DATA_W+1:0] cfg_d1;
  logic [DATA_W+1:0] cfg_d2;
  logic [DATA_W+1:0] cfg_d3;
  wire  [DATA_W+1:0] cfg    = {mode_q, en_q, sign_q};
  wire               steady = (cfg == cfg_d1) && (cfg_d1 == cfg_d2) && (cfg_d2 == cfg_d3);
  wire  [DATA_W-1:0] mag    = i_wdata[DATA_W-1] ? -i_wdata : i_wdata;
  wire               mag_ok = (mag >= FREQ_MIN) && (mag <= FREQ_MAX);
  wire               wr_frq = i_wr && (i_addr == ADDR_FREQ);
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_q <= '0;
      en_q   <= 1'b0;
      sign_q <= 1'b0;
      cfg_d1 <= '0;
      cfg_d2 <= '0;
      cfg_d3 <= '0;
    end else begin
      if (i_wr && i_addr == ADDR_FUNC) mode_q <= i_wdata;
      if (i_wr && i_addr == ADDR_CTRL) en_q <= i_wdata[CTRL_EN_BIT];
      if (wr_frq && mag_ok && !en_q) sign_q <= i_wdata[DATA_W-1];
      cfg_d1 <= cfg;
      cfg_d2 <= cfg_d1;
      cfg_d3 <= cfg_d2;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_duty_err;
    (i_wr && i_addr == ADDR_DUTY && i_wdata > DUTY_MAX) |-> ##2 o_duty_setting_error_flag;
  endproperty
  a_duty_err: assert property (p_duty_err) else $error("duty flag missing");
  property p_freq_err;
    (wr_frq && !mag_ok) |-> ##2 o_frequency_setting_error_flag;
  endproperty
  a_freq_err: assert property (p_freq_err) else $error("freq flag missing");
  property p_err_hold;
    $rose(o_frequency_setting_error_flag) |-> o_frequency_setting_error_flag [*3];
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("freq flag too short");
  property p_err_clear;
    o_duty_setting_error_flag |-> ##[1:HOLD_LIM] !o_duty_setting_error_flag;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("duty flag stuck");
  property p_pw_clear;
    o_pulse_width_error_flag |-> ##[1:HOLD_LIM] !o_pulse_width_error_flag;
  endproperty
  a_pw_clear: assert property (p_pw_clear) else $error("pulse width flag stuck");
  property p_off_quiet;
    (!en_q && !$past(en_q)) |-> !o_first_output_line && !o_second_output_line;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("line active while off");
  property p_pwm_second;
    (steady && mode_q == FUNC_PWM) |-> !o_second_output_line;
  endproperty
  a_pwm_second: assert property (p_pwm_second) else $error("second line in pwm");
  property p_fwd_only;
    (steady && mode_q == FUNC_FWDREV && en_q && !sign_q) |-> !o_second_output_line;
  endproperty
  a_fwd_only: assert property (p_fwd_only) else $error("reverse pulse when positive");
  property p_dir_level;
    (steady && mode_q == FUNC_STEPDIR && en_q) |-> o_second_output_line == sign_q;
  endproperty
  a_dir_level: assert property (p_dir_level) else $error("direction level wrong");
endmodule

// *** tb/ptpwm_load.sv ***
// Purpose: pulse-driven load, counts edges and on time
// Assumes: lines are plain driven outputs
// Notes:   counters clear while i_clr is high
`timescale 1ns/1ps
module ptpwm_load (
  input  wire logic        i_sys_clk,
  input  wire logic        i_clr,
  input  wire logic        i_line1,
  input  wire logic        i_line2,
  output logic      [15:0] o_rise1,
  output logic      [15:0] o_rise2,
  output logic      [23:0] o_hi1
);
  logic l1_d = 1'b0;
  logic l2_d = 1'b0;
  always_ff @(posedge i_sys_clk) begin
    l1_d <= i_line1;
    l2_d <= i_line2;
    if (i_clr) begin
      o_rise1 <= '0;
      o_rise2 <= '0;
      o_hi1   <= '0;
    end else begin
      o_rise1 <= o_rise1 + 16'(i_line1 && !l1_d);
      o_rise2 <= o_rise2 + 16'(i_line2 && !l2_d);
      o_hi1   <= o_hi1 + 24'(i_line1);
    end
  end
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for ptpwm_core
// Assumes: ERR_HOLD shortened to 4 cycles
// Notes:   read results are queued and compared by a watcher
`timescale 1ns/1ps
module tb_top;
  import ptpwm_pkg::*;
  localparam int unsigned EH = 4;
  localparam int          W  = 10000;
  logic              i_sys_clk = 1'b0;
  logic              i_rst     = 1'b1;
  logic              i_wr      = 1'b0;
  logic              i_rd      = 1'b0;
  logic              clr       = 1'b0;
  logic              rd_d      = 1'b0;
  logic [ADDR_W-1:0] i_addr    = '0;
  logic [DATA_W-1:0] i_wdata   = '0;
  logic [DATA_W-1:0] o_rdata;
  logic [DATA_W-1:0] f;
  logic              l1, l2, pe, de, fe;
  logic [15:0]       r1, r2;
  logic [23:0]       h1;
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] bad[4] = '{16'h0031, 16'h1389, 16'hffcf, 16'hec77};
  int                d[3]   = '{0, 30, 100};
  int                error_cnt = 0;
  int                compares  = 0;
  int                cyc       = 0;
  int                seed      = 32'h93e5;
  always #50 i_sys_clk = ~i_sys_clk;
  ptpwm_core #(.ERR_HOLD(EH)) i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_first_output_line(l1),
    .o_second_output_line(l2), .o_pulse_width_error_flag(pe), .o_duty_setting_error_flag(de),
    .o_frequency_setting_error_flag(fe));
  ptpwm_load i_load (.i_sys_clk(i_sys_clk), .i_clr(clr), .i_line1(l1), .i_line2(l2),
    .o_rise1(r1), .o_rise2(r2), .o_hi1(h1));
  task automatic note(string n, logic [23:0] lo, logic [23:0] hi, logic [23:0] got);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %s exp %0d..%0d got %0d", n, lo, hi, got);
    end
  endtask
  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] v);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    q.push_back(e);
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
  endtask
  task automatic win(int n);
    @(posedge i_sys_clk);
    clr <= 1'b1;
    @(posedge i_sys_clk);
    clr <= 1'b0;
    repeat (n) @(posedge i_sys_clk);
  endtask
  // ------------------------------------------------------------------
  // read watcher and timeout
  // ------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    rd_d <= i_rd;
    cyc <= cyc + 1;
    if (rd_d) begin
      note("rdata", q[0], q[0], o_rdata);
      void'(q.pop_front());
    end
    if (cyc == 90000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(ADDR_FUNC, RST_FUNC);
    rd(ADDR_FREQ, RST_FREQ);
    rd(ADDR_DUTY, RST_DUTY);
    rd(ADDR_STATUS, 16'h0000);
    rd(8'h05, 16'h0000);
    wr(ADDR_FUNC, FUNC_FWDREV);
    foreach (bad[i]) begin
      wr(ADDR_FREQ, bad[i]);
      rd(ADDR_STATUS, 16'h0004);
      note("freqpin", 1, 1, fe);
    end
    repeat (10) @(posedge i_sys_clk);
    note("freqclr", 0, 0, fe);
    rd(ADDR_FREQ, RST_FREQ);
    wr(ADDR_FREQ, FREQ_MAX);
    wr(ADDR_CTRL, 16'h0001);
    win(W);
    note("fwd", 4, 6, r1);
    note("rev", 0, 0, r2);
    note("half", 4980, 5020, h1);
    wr(ADDR_FREQ, 16'hec78);
    rd(ADDR_STATUS, 16'h000c);
    rd(ADDR_FREQ, FREQ_MAX);
    f = 16'(2000 + $unsigned($random(seed)) % 3001);
    wr(ADDR_FREQ, f);
    win(W);
    note("newf", 24'(f / 1000 - 1), 24'(f / 1000 + 1), r1);
    wr(ADDR_CTRL, 16'h0000);
    repeat (4) @(posedge i_sys_clk);
    note("off1", 0, 0, l1);
    note("off2", 0, 0, l2);
    wr(ADDR_FREQ, 16'hf830);
    wr(ADDR_FUNC, FUNC_STEPDIR);
    wr(ADDR_CTRL, 16'h0001);
    win(W);
    note("step", 1, 3, r1);
    note("dir", 1, 1, l2);
    note("dirhold", 0, 0, r2);
    rd(ADDR_STATUS, 16'h0018);
    wr(ADDR_FUNC, FUNC_FWDREV);
    win(W);
    note("rev", 1, 3, r2);
    note("fwd0", 0, 0, r1);
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_FREQ, 16'h03e8);
    wr(ADDR_FUNC, FUNC_PWM);
    wr(ADDR_DUTY, 16'h0032);
    wr(ADDR_CTRL, 16'h0001);
    foreach (d[i]) begin
      wr(ADDR_DUTY, 16'(d[i]));
      win(W);
      note("duty", 24'((d[i] > 0) ? d[i] * 100 - 20 : 0), 24'(d[i] * 100 + 20), h1);
      note("pwm2", 0, 0, r2);
    end
    wr(ADDR_DUTY, 16'h0005);
    rd(ADDR_STATUS, 16'h0009);
    note("pwpin", 1, 1, pe);
    repeat (10) @(posedge i_sys_clk);
    note("pwclr", 0, 0, pe);
    wr(ADDR_DUTY, 16'h0065);
    rd(ADDR_STATUS, 16'h000a);
    note("dutypin", 1, 1, de);
    rd(ADDR_DUTY, 16'h0005);
    wr(ADDR_CTRL, 16'h0000);
    repeat (4) @(posedge i_sys_clk);
    note("pwmoff", 0, 0, l1);
    note("pwoff", 0, 0, pe);
    close_out();
  end
endmodule
bind ptpwm_core ptpwm_chk #(.ERR_HOLD(ERR_HOLD)) i_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_first_output_line(o_first_output_line), .o_second_output_line(o_second_output_line),
  .o_pulse_width_error_flag(o_pulse_width_error_flag), .o_duty_setting_error_flag(o_duty_setting_error_flag),
  .o_frequency_setting_error_flag(o_frequency_setting_error_flag));
